// File: src/lpm_consts.svh
/*
  Constants of the low-power mode sequencer: register offsets, field
  positions, reset values and timing counts.
  Assumes inclusion by bare name from the sequencer, the assertions and the bench.
*/
`ifndef LPM_CONSTS_SVH
`define LPM_CONSTS_SVH

`define LPM_OFS_CTRL 12'h000
`define LPM_OFS_WMASK 12'h004
`define LPM_OFS_STATUS 12'h008
`define LPM_OFS_IRQ_STAT 12'h00C
`define LPM_OFS_IRQ_MASK 12'h010
`define LPM_OFS_DRIVE 12'h014
`define LPM_OFS_WAKE_PEND 12'h018

`define LPM_CTRL_SEL_LO 0
`define LPM_CTRL_SEL_HI 1
`define LPM_CTRL_RETAIN 2
`define LPM_CTRL_CORE_PDN 3
`define LPM_CTRL_MEM_PDN 4
`define LPM_CTRL_DS_ALLOW 5
`define LPM_CTRL_STBY_EN 6
`define LPM_CTRL_W 7

`define LPM_SEL_WAIT 2'h0
`define LPM_SEL_STOP 2'h1

`define LPM_IRQ_SLEEP 0
`define LPM_IRQ_WAKE 1
`define LPM_IRQ_WAIT 2
`define LPM_IRQ_W 3

`define LPM_CTRL_RST 7'h00
`define LPM_WMASK_RST 32'hFFFF_FFFF
`define LPM_IRQ_MASK_RST 3'h0
`define LPM_DRIVE_RST 3'h7
`define LPM_DRIVE_LOW 3'h1

`define LPM_CLK_MHZ 250
`define LPM_ENTRY_NS 16
`define LPM_EXIT_NS 16
`define LPM_ENTRY_CYC ((`LPM_ENTRY_NS * `LPM_CLK_MHZ + 999) / 1000)
`define LPM_EXIT_CYC ((`LPM_EXIT_NS * `LPM_CLK_MHZ + 999) / 1000)

`endif

// File: src/lpm_pkg.sv
/*
  Types of the low-power mode sequencer: states, modes and the control
  bundles that go to the clock, power and memory logic.
  Assumes lpm_consts.svh is on the include path.
*/
`default_nettype none

package lpm_pkg;

  typedef enum logic [2:0] {
    LPM_ST_RUN,
    LPM_ST_WAIT,
    LPM_ST_ENTER,
    LPM_ST_STOP,
    LPM_ST_DORM,
    LPM_ST_EXIT
  } lpm_state_t;

  typedef enum logic [2:0] {
    LPM_MODE_RUN,
    LPM_MODE_WAIT,
    LPM_MODE_STOP,
    LPM_MODE_DORMANT,
    LPM_MODE_RETENTION
  } lpm_mode_t;

  typedef struct packed {
    logic core_clk_en;
    logic pll_en;
    logic fast_osc_en;
    logic slow_osc_en;
  } lpm_clk_t;

  typedef struct packed {
    logic core_pwr;
    logic mem_periph_pwr;
    logic general_domains_pwr;
    logic retention_pwr;
    logic backup_pwr;
    logic dram_pwr;
  } lpm_pwr_t;

  typedef struct packed {
    logic blocks_low_power;
    logic self_refresh;
    logic [2:0] dram_drive;
  } lpm_mem_t;

endpackage

`default_nettype wire

// File: src/lpm_wake_gate.sv
/*
  Wakeup interrupt gate: one bit per source is kept only where the mask
  leaves it open, and the pending vector and its OR are registered.
  Assumes wake sources are levels synchronous to clk_sys.
*/
`default_nettype none

module lpm_wake_gate
  import lpm_pkg::*;
(
  // Clock and reset
  input wire logic clk_sys,
  input wire logic arst_n,
  // Sources and mask, a set mask bit blocks its source
  input wire logic [31:0] wake_irq,
  input wire logic [31:0] wake_mask,
  // Gated result
  output logic [31:0] wake_pend,
  output logic wake_any
);

  logic [31:0] pend_nxt;

  genvar gi;
  generate
    for (gi = 0; gi < 32; gi = gi + 1) begin : g_bit
      assign pend_nxt[gi] = wake_irq[gi] & ~wake_mask[gi]; // R9
    end
  endgenerate

  // One process owns the whole vector, so each bit has a single driver
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      wake_pend <= 32'h0000_0000;
      wake_any <= 1'b0;
    end else begin
      wake_pend <= pend_nxt;
      wake_any <= |pend_nxt;
    end
  end

endmodule

`default_nettype wire

// File: src/lpm_sequencer.sv
/*
  Low-power mode sequencer with its APB register file and interrupt.
  Moves the chip between run, wait, stop, dormant and retention, drives
  clock, power-domain, DRAM pad and PMIC standby controls.
  Assumes the core's sleep and wake signals are synchronous to clk_sys
  and that the core saves its context while core_ctx_save is high.
*/
// Notes on behaviour
// R1 - Five modes, exactly one held current
// R2 - Clocks and oscillators follow the current mode
// R3 - Stop: blocks low, core powered, self-refresh
// R4 - Dormant: everything low, only DRAM self-refresh
// R5 - Retention: only retention, backup, DRAM domains; code keeps core, memory peripherals on unless core_pdn_en, mem_pdn_en
// R6 - Core requests wait while companion is busy
// R7 - Dormant: core power off on power-down request
// R8 - Stop/dormant: memory peripherals off on request
// R9 - Only unmasked interrupts may wake the chip
// R10 - Unmasked wake returns to run, restores state
// R11 - Dormant entry lowers DRAM pad drive first
// R12 - Dormant may raise the PMIC standby request
// R13 - Deep sleep permitted and configured beforehand
// R14 - Deep entry needs wfi plus deep-sleep request
`include "lpm_consts.svh"
`default_nettype none

module lpm_sequencer
  import lpm_pkg::*;
(
  // Clock and reset
  input wire logic clk_sys,
  input wire logic arst_n,
  // APB slave
  input wire logic [11:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Core sleep handshake
  input wire logic core_deep_sleep_req,
  input wire logic core_wfi_pending,
  input wire logic [31:0] wake_irq,
  output logic core_ctx_save,
  output logic core_ctx_restore,
  // Power, clock and memory controls
  output logic pdn_req,
  output lpm_clk_t clk_ctrl,
  output lpm_pwr_t pwr_ctrl,
  output lpm_mem_t mem_ctrl,
  output logic pmic_standby_request,
  // Interrupt
  output logic irq
);

  localparam logic [2:0] ENTRY_CYC = 3'(`LPM_ENTRY_CYC);
  localparam logic [2:0] EXIT_CYC = 3'(`LPM_EXIT_CYC);

  lpm_state_t state_r, state_nxt;
  lpm_mode_t mode_r, mode_nxt;
  lpm_mode_t tgt_r, tgt_nxt;
  logic [2:0] cnt_r, cnt_nxt;
  logic [`LPM_CTRL_W-1:0] ctrl_r;
  logic [31:0] wmask_r;
  logic [2:0] irq_stat_r, irq_mask_r, drive_r;
  logic [31:0] prdata_nxt;
  logic [31:0] wake_pend;
  logic wake_any;
  lpm_clk_t clk_nxt;
  lpm_pwr_t pwr_nxt;
  lpm_mem_t mem_nxt;
  logic pdn_nxt, stby_nxt, save_nxt, restore_nxt;

  // Bus decode
  wire apb_setup = psel & ~penable;
  wire apb_acc = psel & penable;
  wire sel_ctrl = (paddr == `LPM_OFS_CTRL);
  wire sel_wmask = (paddr == `LPM_OFS_WMASK);
  wire sel_status = (paddr == `LPM_OFS_STATUS);
  wire sel_istat = (paddr == `LPM_OFS_IRQ_STAT);
  wire sel_imask = (paddr == `LPM_OFS_IRQ_MASK);
  wire sel_drive = (paddr == `LPM_OFS_DRIVE);
  wire sel_pend = (paddr == `LPM_OFS_WAKE_PEND);
  wire mapped = sel_ctrl | sel_wmask | sel_status | sel_istat |
                sel_imask | sel_drive | sel_pend;
  wire wr = apb_acc & pwrite & mapped;
  wire rd_istat = apb_acc & ~pwrite & sel_istat;
  wire [31:0] bmask = {{8{pstrb[3]}}, {8{pstrb[2]}},
                       {8{pstrb[1]}}, {8{pstrb[0]}}};
  wire [31:0] wmask_wr = (wmask_r & ~bmask) | (pwdata & bmask);

  assign pready = 1'b1;
  assign pslverr = apb_acc & ~mapped;

  // Control fields
  wire [1:0] mode_sel = ctrl_r[`LPM_CTRL_SEL_HI:`LPM_CTRL_SEL_LO];
  wire retain_sel = ctrl_r[`LPM_CTRL_RETAIN];
  wire core_pdn_en = ctrl_r[`LPM_CTRL_CORE_PDN];
  wire mem_pdn_en = ctrl_r[`LPM_CTRL_MEM_PDN];
  wire ds_allow = ctrl_r[`LPM_CTRL_DS_ALLOW];
  wire stby_en = ctrl_r[`LPM_CTRL_STBY_EN];

  // Deep sleep is taken only when software has armed it
  wire deep_ok = core_wfi_pending & core_deep_sleep_req & ds_allow &
                 (mode_sel != `LPM_SEL_WAIT); // R13 R14
  wire deep_is_stop = (mode_sel == `LPM_SEL_STOP);
  wire tgt_deep = (tgt_r == LPM_MODE_DORMANT) |
                  (tgt_r == LPM_MODE_RETENTION);

  lpm_wake_gate u_wake (
    .clk_sys(clk_sys),
    .arst_n(arst_n),
    .wake_irq(wake_irq),
    .wake_mask(wmask_r),
    .wake_pend(wake_pend),
    .wake_any(wake_any)
  );

  // Sequencing
  always_comb begin
    state_nxt = state_r;
    tgt_nxt = tgt_r;
    cnt_nxt = cnt_r;
    unique case (state_r)
      LPM_ST_RUN: begin
        if (deep_ok) begin // R14
          state_nxt = LPM_ST_ENTER;
          cnt_nxt = ENTRY_CYC;
          if (deep_is_stop) begin
            tgt_nxt = LPM_MODE_STOP;
          end else if (retain_sel) begin
            tgt_nxt = LPM_MODE_RETENTION; // R5
          end else begin
            tgt_nxt = LPM_MODE_DORMANT;
          end
        end else if (core_wfi_pending) begin
          state_nxt = LPM_ST_WAIT; // R14
        end
      end
      LPM_ST_WAIT: begin
        // Any unmasked wake or the core leaving wfi ends wait
        if (wake_any | ~core_wfi_pending) begin
          state_nxt = LPM_ST_RUN;
        end
      end
      LPM_ST_ENTER: begin
        if (wake_any) begin
          state_nxt = LPM_ST_EXIT; // R10
          cnt_nxt = EXIT_CYC;
        end else if (cnt_r == 3'h1) begin
          state_nxt = tgt_deep ? LPM_ST_DORM : LPM_ST_STOP;
        end else begin
          cnt_nxt = cnt_r - 3'h1;
        end
      end
      LPM_ST_STOP, LPM_ST_DORM: begin
        if (wake_any) begin // R9 R10
          state_nxt = LPM_ST_EXIT;
          cnt_nxt = EXIT_CYC;
        end
      end
      LPM_ST_EXIT: begin
        if (cnt_r == 3'h1) begin
          state_nxt = LPM_ST_RUN; // R10
        end else begin
          cnt_nxt = cnt_r - 3'h1;
        end
      end
      default: begin
        state_nxt = LPM_ST_RUN;
      end
    endcase
  end

  // Current mode, one value at a time
  always_comb begin
    unique case (state_nxt)
      LPM_ST_WAIT: mode_nxt = LPM_MODE_WAIT;
      LPM_ST_STOP, LPM_ST_DORM: mode_nxt = tgt_nxt; // R1
      default: mode_nxt = LPM_MODE_RUN;
    endcase
  end

  // Controls decoded from the next state so they align with state_r
  wire n_enter = (state_nxt == LPM_ST_ENTER);
  wire n_stop = (state_nxt == LPM_ST_STOP);
  wire n_dorm = (state_nxt == LPM_ST_DORM);
  wire n_wait = (state_nxt == LPM_ST_WAIT);
  wire n_exit = (state_nxt == LPM_ST_EXIT);
  wire n_low = n_enter | n_stop | n_dorm;
  wire n_retain = n_dorm & (tgt_nxt == LPM_MODE_RETENTION);
  wire n_deep_tgt = (tgt_nxt == LPM_MODE_DORMANT) |
                    (tgt_nxt == LPM_MODE_RETENTION);

  always_comb begin
    clk_nxt.core_clk_en = ~(n_wait | n_low); // R2
    clk_nxt.pll_en = ~(n_stop | n_dorm); // R2
    clk_nxt.fast_osc_en = ~n_dorm; // R2
    clk_nxt.slow_osc_en = 1'b1; // R2
    pdn_nxt = n_stop | n_dorm;
    // Core keeps power in stop; dormant drops it on request
    pwr_nxt.core_pwr = ~(n_dorm & pdn_nxt & core_pdn_en); // R3 R4 R7
    pwr_nxt.mem_periph_pwr = ~(pdn_nxt & mem_pdn_en); // R8
    pwr_nxt.general_domains_pwr = ~n_retain; // R5
    pwr_nxt.retention_pwr = 1'b1; // R5
    pwr_nxt.backup_pwr = 1'b1; // R5
    pwr_nxt.dram_pwr = 1'b1; // R5
    mem_nxt.blocks_low_power = n_low; // R3 R4
    mem_nxt.self_refresh = n_low; // R3 R4
    // Low drive set on dormant or retention entry, before power-down, and held until an unmasked wake starts the exit
    mem_nxt.dram_drive = (n_low & n_deep_tgt) ?
                         `LPM_DRIVE_LOW : drive_r; // R11 R10
    stby_nxt = n_dorm & stby_en; // R12
    save_nxt = n_enter & (state_r == LPM_ST_RUN) & n_deep_tgt;
    restore_nxt = n_exit & (state_r != LPM_ST_EXIT) & tgt_deep; // R10
  end

  // Read mux, captured in the setup cycle
  wire [31:0] status_word = {26'h000_0000, pmic_standby_request, pdn_req,
                             1'b0, 3'(mode_r)};
  always_comb begin
    prdata_nxt = 32'h0000_0000;
    if (sel_ctrl) begin
      prdata_nxt = {25'h000_0000, ctrl_r};
    end else if (sel_wmask) begin
      prdata_nxt = wmask_r;
    end else if (sel_status) begin
      prdata_nxt = status_word;
    end else if (sel_istat) begin
      prdata_nxt = {29'h0000_0000, irq_stat_r};
    end else if (sel_imask) begin
      prdata_nxt = {29'h0000_0000, irq_mask_r};
    end else if (sel_drive) begin
      prdata_nxt = {29'h0000_0000, drive_r};
    end else if (sel_pend) begin
      prdata_nxt = wake_pend;
    end
  end

  // Events; a new event wins over the read that clears
  wire [2:0] ev;
  assign ev[`LPM_IRQ_SLEEP] = (state_r == LPM_ST_ENTER) &
                              (n_stop | n_dorm);
  assign ev[`LPM_IRQ_WAKE] = n_exit & (state_r != LPM_ST_EXIT);
  assign ev[`LPM_IRQ_WAIT] = n_wait & (state_r != LPM_ST_WAIT);
  // Clear only what the read returned: an event in the setup cycle survives
  wire [2:0] istat_clr = rd_istat ? prdata[2:0] : 3'h0;
  wire [2:0] istat_nxt = (irq_stat_r & ~istat_clr) | ev;

  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      state_r <= LPM_ST_RUN;
      mode_r <= LPM_MODE_RUN;
      tgt_r <= LPM_MODE_STOP;
      cnt_r <= 3'h0;
    end else begin
      state_r <= state_nxt;
      mode_r <= mode_nxt;
      tgt_r <= tgt_nxt;
      cnt_r <= cnt_nxt;
    end
  end

  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      clk_ctrl <= '1;
      pwr_ctrl <= '1;
      mem_ctrl <= {2'b00, `LPM_DRIVE_RST};
      pdn_req <= 1'b0;
      pmic_standby_request <= 1'b0;
      core_ctx_save <= 1'b0;
      core_ctx_restore <= 1'b0;
    end else begin
      clk_ctrl <= clk_nxt;
      pwr_ctrl <= pwr_nxt;
      mem_ctrl <= mem_nxt;
      pdn_req <= pdn_nxt;
      pmic_standby_request <= stby_nxt;
      core_ctx_save <= save_nxt;
      core_ctx_restore <= restore_nxt;
    end
  end

  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      ctrl_r <= `LPM_CTRL_RST;
      wmask_r <= `LPM_WMASK_RST;
      irq_mask_r <= `LPM_IRQ_MASK_RST;
      drive_r <= `LPM_DRIVE_RST;
    end else if (wr) begin
      if (sel_ctrl & pstrb[0]) begin
        ctrl_r <= pwdata[`LPM_CTRL_W-1:0];
      end
      if (sel_wmask) begin
        wmask_r <= wmask_wr;
      end
      if (sel_imask & pstrb[0]) begin
        irq_mask_r <= pwdata[2:0];
      end
      if (sel_drive & pstrb[0]) begin
        drive_r <= pwdata[2:0];
      end
    end
  end

  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      irq_stat_r <= 3'h0;
      prdata <= 32'h0000_0000;
      irq <= 1'b0;
    end else begin
      irq_stat_r <= istat_nxt;
      irq <= |(istat_nxt & irq_mask_r);
      if (apb_setup) begin
        prdata <= prdata_nxt;
      end
    end
  end

endmodule

`default_nettype wire

// File: tb/lpm_sva.sv
/*
  Port assertions for the low-power mode sequencer.
  Assumes it is bound to lpm_sequencer and shares its clock and reset.
*/
`include "lpm_consts.svh"
`default_nettype none
module lpm_sva
  import lpm_pkg::*;
(
  // Clock and reset
  input wire logic clk_sys,
  input wire logic arst_n,
  // Core handshake
  input wire logic core_deep_sleep_req,
  input wire logic core_wfi_pending,
  input wire logic core_ctx_save,
  input wire logic core_ctx_restore,
  // Controls
  input wire logic pdn_req,
  input wire lpm_clk_t clk_ctrl,
  input wire lpm_pwr_t pwr_ctrl,
  input wire lpm_mem_t mem_ctrl,
  input wire logic pmic_standby_request
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge clk_sys);
  endclocking
  default disable iff (!arst_n);
  pll_gate_a: assert property (
    !clk_ctrl.pll_en |-> !clk_ctrl.core_clk_en && clk_ctrl.slow_osc_en)
    else $error("pll off with core clock or slow osc wrong");
  stop_keeps_core_a: assert property (
    pdn_req && clk_ctrl.fast_osc_en |-> pwr_ctrl.core_pwr &&
    mem_ctrl.self_refresh && mem_ctrl.blocks_low_power)
    else $error("stop without core power or self refresh");
  dormant_dram_a: assert property (
    !clk_ctrl.fast_osc_en |-> pdn_req && mem_ctrl.self_refresh &&
    pwr_ctrl.dram_pwr && !clk_ctrl.pll_en)
    else $error("fast osc off outside a deep mode");
  retention_keep_a: assert property (
    !pwr_ctrl.general_domains_pwr |-> pwr_ctrl.retention_pwr &&
    pwr_ctrl.backup_pwr && pwr_ctrl.dram_pwr && !clk_ctrl.fast_osc_en)
    else $error("retention domains dropped");
  core_off_cause_a: assert property (
    !pwr_ctrl.core_pwr |-> pdn_req && !clk_ctrl.fast_osc_en)
    else $error("core power off outside dormant");
  mem_off_cause_a: assert property (
    !pwr_ctrl.mem_periph_pwr |-> pdn_req)
    else $error("memory peripherals off without power down");
  save_drive_a: assert property (
    core_ctx_save |-> mem_ctrl.dram_drive == `LPM_DRIVE_LOW ##1
    !core_ctx_save)
    else $error("save pulse without low drive or too long");
  restore_run_a: assert property (
    core_ctx_restore |-> !pdn_req && clk_ctrl == 4'hF ##1 !core_ctx_restore)
    else $error("restore pulse with clocks off or too long");
  standby_dorm_a: assert property (
    pmic_standby_request |-> pdn_req && !clk_ctrl.fast_osc_en)
    else $error("standby request outside dormant");
  entry_cause_a: assert property (
    $rose(mem_ctrl.self_refresh) |-> $past(core_wfi_pending) &&
    $past(core_deep_sleep_req))
    else $error("deep entry without wfi and deep request");
  entry_delay_a: assert property (
    $rose(pdn_req) |-> $past(mem_ctrl.self_refresh, 4))
    else $error("power down before entry phase ran out");
endmodule
`default_nettype wire

// File: tb/lpm_core_model.sv
/*
  Behavioural model of the application core's sleep side.
  Assumes the testbench changes its commands right after rising edges.
*/
`default_nettype none
module lpm_core_model (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic arst_n,
  // Commands from the bench
  input wire logic sleep_cmd,
  input wire logic companion_busy,
  input wire logic [31:0] wake_src,
  // Core sleep signals
  output logic core_deep_sleep_req,
  output logic core_wfi_pending,
  output logic [31:0] wake_irq
);
  timeunit 1ns;
  timeprecision 1ps;
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      core_deep_sleep_req <= 1'h0;
      core_wfi_pending <= 1'h0;
      wake_irq <= 32'h0;
    end else begin
      // A busy companion must keep running, so only a shallow sleep
      core_deep_sleep_req <= sleep_cmd & ~companion_busy;
      core_wfi_pending <= sleep_cmd;
      wake_irq <= wake_src;
    end
  end
endmodule
`default_nettype wire

// File: tb/tb_top.sv
/*
  Self-checking bench of the low-power mode sequencer: APB master,
  core model, table and random sleep cases.
  Assumes package, design and model are compiled before it.
*/
`include "lpm_consts.svh"
`default_nettype none
module tb_top
  import lpm_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk_sys, arst_n, psel, penable, pwrite, pready, pslverr, irq;
  logic core_deep_sleep_req, core_wfi_pending, core_ctx_save;
  logic core_ctx_restore, pdn_req, pmic_standby_request, serr;
  logic sleep_cmd, companion_busy;
  logic [11:0] paddr;
  logic [3:0] pstrb;
  logic [31:0] pwdata, prdata, wake_irq, wake_src, q;
  lpm_clk_t clk_ctrl;
  lpm_pwr_t pwr_ctrl;
  lpm_mem_t mem_ctrl;
  logic [16:0] outs;
  int err_count, checks, seed;
  int n_save = 0;
  int n_rest = 0;
  logic [31:0] rst_tab [6] = '{32'h0, 32'hFFFF_FFFF, 32'h0, 32'h0, 32'h0,
    32'h7};
  logic [6:0] ctab [7] = '{7'h20, 7'h31, 7'h01, 7'h31, 7'h6A, 7'h7E, 7'h23};
  assign outs = {pdn_req, clk_ctrl, pwr_ctrl, mem_ctrl, pmic_standby_request};
  lpm_sequencer lpm_sequencer_inst (
    .clk_sys(clk_sys),
    .arst_n(arst_n),
    .paddr(paddr),
    .psel(psel),
    .penable(penable),
    .pwrite(pwrite),
    .pwdata(pwdata),
    .pstrb(pstrb),
    .prdata(prdata),
    .pready(pready),
    .pslverr(pslverr),
    .core_deep_sleep_req(core_deep_sleep_req),
    .core_wfi_pending(core_wfi_pending),
    .wake_irq(wake_irq),
    .core_ctx_save(core_ctx_save),
    .core_ctx_restore(core_ctx_restore),
    .pdn_req(pdn_req),
    .clk_ctrl(clk_ctrl),
    .pwr_ctrl(pwr_ctrl),
    .mem_ctrl(mem_ctrl),
    .pmic_standby_request(pmic_standby_request),
    .irq(irq)
  );
  lpm_core_model lpm_core_model_inst (
    .clk_sys(clk_sys),
    .arst_n(arst_n),
    .sleep_cmd(sleep_cmd),
    .companion_busy(companion_busy),
    .wake_src(wake_src),
    .core_deep_sleep_req(core_deep_sleep_req),
    .core_wfi_pending(core_wfi_pending),
    .wake_irq(wake_irq)
  );
  // Count context pulses so each scenario can expect exactly one or none
  always @(posedge clk_sys) begin
    n_save <= n_save + int'(core_ctx_save);
    n_rest <= n_rest + int'(core_ctx_restore);
  end
  initial begin
    clk_sys = 1'h0;
    forever #2 clk_sys = ~clk_sys;
  end
  task automatic chk_val(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      err_count++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic apb(input logic w, input logic [11:0] a,
      input logic [31:0] d);
    @(posedge clk_sys);
    psel <= 1'h1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk_sys);
    penable <= 1'h1;
    do begin
      @(posedge clk_sys);
    end while (pready !== 1'h1);
    q = prdata;
    serr = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
  endtask
  function automatic logic [2:0] mode_of(logic [6:0] c, logic b);
    if (!c[5] || c[1:0] == 2'h0 || b) return 3'h1;
    if (!c[1]) return 3'h2;
    return c[2] ? 3'h4 : 3'h3;
  endfunction
  function automatic logic [16:0] exp_out(logic [2:0] m, logic [6:0] c,
      logic [2:0] drv);
    logic dp;
    dp = m > 3'h2;
    if (m < 3'h2) return {1'h0, m == 3'h0, 3'h7, 6'h3F, 2'h0, drv, 1'h0};
    return {3'h4, !dp, 1'h1, !(dp && c[3]), !c[4], m != 3'h4, 3'h7,
      2'h3, dp ? 3'h1 : drv, dp && c[6]};
  endfunction
  task automatic sleep_case(input logic [6:0] c, input logic b,
      input logic [2:0] im);
    logic [2:0] m, drv, st;
    logic [4:0] k;
    logic [16:0] eo;
    int s0, r0;
    m = mode_of(c, b);
    drv = 3'($random(seed));
    k = 5'($random(seed));
    eo = exp_out(m, c, drv);
    st = m > 3'h1 ? 3'h3 : 3'h4;
    apb(1'h1, `LPM_OFS_DRIVE, {29'h0, drv});
    apb(1'h1, `LPM_OFS_WMASK, ~(32'h1 << k));
    apb(1'h1, `LPM_OFS_IRQ_MASK, {29'h0, im});
    apb(1'h1, `LPM_OFS_CTRL, {25'h0, c});
    s0 = n_save;
    r0 = n_rest;
    companion_busy <= b;
    sleep_cmd <= 1'h1;
    repeat (12) @(posedge clk_sys);
    chk_val({15'h0, outs}, {15'h0, eo});
    apb(1'h0, `LPM_OFS_STATUS, 32'h0);
    chk_val(q, {26'h0, eo[0], eo[16], 1'h0, m});
    if (m > 3'h1) begin
      // A blocked source first: the chip must sleep on through it
      wake_src <= 32'h1 << (k + 5'h1);
      repeat (8) @(posedge clk_sys);
      chk_val({15'h0, outs}, {15'h0, eo});
      wake_src <= 32'h1 << k;
      repeat (4) @(posedge clk_sys);
    end
    sleep_cmd <= 1'h0;
    wake_src <= 32'h0;
    repeat (12) @(posedge clk_sys);
    chk_val({15'h0, outs}, {15'h0, exp_out(3'h0, c, drv)});
    chk_val(32'(n_save - s0), {31'h0, m > 3'h2});
    chk_val(32'(n_rest - r0), {31'h0, m > 3'h2});
    chk_val({31'h0, irq}, {31'h0, |(st & im)});
    apb(1'h0, `LPM_OFS_IRQ_STAT, 32'h0);
    chk_val(q, {29'h0, st});
    apb(1'h0, `LPM_OFS_IRQ_STAT, 32'h0);
    chk_val({q[31:1], irq}, 32'h0);
    $display("sleep case ctrl %h mode %0d done", c, m);
  endtask
  task automatic test_done;
    $display("checks %0d mismatches %0d", checks, err_count);
    if (err_count == 0 && checks > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  initial begin
    {psel, penable, pwrite, sleep_cmd, companion_busy} = 5'h0;
    paddr = 12'h0;
    pwdata = 32'h0;
    pstrb = 4'hF;
    wake_src = 32'h0;
    err_count = 0;
    checks = 0;
    seed = 32'h86d2_da10;
    arst_n = 1'h0;
    repeat (12) @(posedge clk_sys);
    arst_n <= 1'h1;
    for (int i = 0; i < 6; i++) begin
      apb(1'h0, 12'(4 * i), 32'h0);
      chk_val(q, rst_tab[i]);
    end
    chk_val({15'h0, outs}, {15'h0, exp_out(3'h0, 7'h0, 3'h7)});
    chk_val({31'h0, pready}, 32'h1);
    apb(1'h1, `LPM_OFS_STATUS, 32'h7);
    apb(1'h0, 12'h01C, 32'h0);
    chk_val({q[31:1], serr}, 32'h1);
    apb(1'h0, `LPM_OFS_STATUS, 32'h0);
    chk_val(q, 32'h0);
    $display("reset and map test done");
    for (int i = 0; i < 7; i++)
      sleep_case(ctab[i], i == 3, 3'h7);
    repeat (16)
      sleep_case(7'($random(seed)), 1'($random(seed)), 3'($random(seed)));
    test_done;
  end
  initial begin
    repeat (30000) @(posedge clk_sys);
    err_count++;
    test_done;
  end
endmodule
bind lpm_sequencer lpm_sva lpm_sva_inst (
  .clk_sys(clk_sys),
  .arst_n(arst_n),
  .core_deep_sleep_req(core_deep_sleep_req),
  .core_wfi_pending(core_wfi_pending),
  .core_ctx_save(core_ctx_save),
  .core_ctx_restore(core_ctx_restore),
  .pdn_req(pdn_req),
  .clk_ctrl(clk_ctrl),
  .pwr_ctrl(pwr_ctrl),
  .mem_ctrl(mem_ctrl),
  .pmic_standby_request(pmic_standby_request)
);
`default_nettype wire
